// ==== pkg/dasq_params.svh ====
`ifndef DASQ_PARAMS_SVH
`define DASQ_PARAMS_SVH
// Summary of operation
// R1: Single, triggered or continuous scan modes.
// R2: Eight inputs feed two 12-bit converters.
// R3: Converters store results in readable buffers.
// R4: Control bit selects sequential or simultaneous.
// R5: Sequential scan follows eight-slot channel list.
// R6: Sequential slot uses converter owning its input.
// R7: Simultaneous mode samples two channels together.
// R8: Software never pairs one input twice.
// R9: End-of-scan interrupt on limit violation.
// R10: Selectable zero-crossing interrupt conditions.
// R11: Trigger starts one scan; ignored while busy.

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define DASQ_CTRL_OFS 8'h00
`define DASQ_STAT_OFS 8'h04
`define DASQ_LIST_OFS 8'h08
`define DASQ_ZCSEL_OFS 8'h0C
`define DASQ_IRQST_OFS 8'h10
`define DASQ_IRQMSK_OFS 8'h14
// Word arrays selected by address bits [7:5], slot by [4:2]
`define DASQ_RES_BLK 3'h1
`define DASQ_LOLIM_BLK 3'h2
`define DASQ_HILIM_BLK 3'h3

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define DASQ_CTRL_SIMUL_BIT 2
`define DASQ_CTRL_START_BIT 3
`define DASQ_CTRL_STOP_BIT 4
`define DASQ_LIST_LAST_LSB 24
`define DASQ_IRQ_DONE_BIT 0
`define DASQ_IRQ_LIMIT_BIT 1
`define DASQ_IRQ_ZC_BIT 2

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define DASQ_LIST_RST 27'h7FA_C688
`define DASQ_LOLIM_RST 12'h000
`define DASQ_HILIM_RST 12'hFFF
`define DASQ_ZCSEL_RST 16'h0000
`define DASQ_IRQ_RST 3'h0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define DASQ_CLK_PERIOD_NS 50
`define DASQ_CONV_TIME_NS 1000
`define DASQ_CONV_CYCLES \
  ((`DASQ_CONV_TIME_NS + `DASQ_CLK_PERIOD_NS - 1) / `DASQ_CLK_PERIOD_NS)
`endif

// ==== pkg/dasq_pkg.sv ====
package dasq_pkg;
  // Scan behaviour; code 2'b11 is illegal and acts as single scan
  typedef enum logic [1:0] {
    MODE_ONCE = 2'b00,
    MODE_TRIG = 2'b01,
    MODE_LOOP = 2'b10
  } dasq_mode_t;
  // Sequencer states, Gray along idle-start-wait
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_WAIT = 2'b11
  } dasq_state_t;
endpackage

// ==== pkg/dasq_conv_if.sv ====
`timescale 1ns/1ps
// Link between the sequencer and one converter slice
interface dasq_conv_if;
  logic start;
  logic [11:0] sample;
  logic [11:0] lowLimit;
  logic [11:0] highLimit;
  logic [1:0] zcMode;
  logic [11:0] prevResult;
  logic done;
  logic [11:0] result;
  logic outOfRange;
  logic zeroCross;
  modport seq (output start, sample, lowLimit, highLimit, zcMode,
    prevResult, input done, result, outOfRange, zeroCross);
  modport conv (input start, sample, lowLimit, highLimit, zcMode,
    prevResult, output done, result, outOfRange, zeroCross);
endinterface

// ==== rtl/dasq_conv_slice.sv ====
`timescale 1ns/1ps
`include "dasq_params.svh"

module dasq_conv_slice #(
  parameter int CONV_CYCLES = `DASQ_CONV_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  dasq_conv_if.conv cif
);
  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam int DoneLat = CONV_CYCLES + 1;

  logic [11:0] held; // Sample-and-hold value
  logic busy; // Conversion in progress
  logic [CW-1:0] count; // Cycles left in the conversion
  logic newSign; // Held value at or above midscale
  logic oldSign; // Previous result at or above midscale
  logic crossing; // Sign change matching the selected mode

  // ---------------------------------------------------------------
  // Sample and conversion timing
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      held <= 12'h000;
      busy <= 1'b0;
      count <= '0;
    end else if (ce) begin
      if (cif.start) begin
        // Capture on the start cycle so two slices sample together
        held <= cif.sample; // R2
        busy <= 1'b1;
        count <= CW'(CONV_CYCLES - 1);
      end else if (busy) begin
        if (count == '0) begin
          busy <= 1'b0;
        end else begin
          count <= count - 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Result checks
  // ---------------------------------------------------------------
  // Midscale is the zero line of a bipolar signal
  assign newSign = held[11];
  assign oldSign = cif.prevResult[11];

  always_comb begin
    unique case (cif.zcMode)
      2'b01: crossing = !oldSign && newSign; // Rising through zero
      2'b10: crossing = oldSign && !newSign; // Falling through zero
      2'b11: crossing = oldSign != newSign; // Either direction
      default: crossing = 1'b0; // Detection off
    endcase
  end

  // Result and flags leave on a one-cycle done pulse
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cif.done <= 1'b0;
      cif.result <= 12'h000;
      cif.outOfRange <= 1'b0;
      cif.zeroCross <= 1'b0;
    end else if (ce) begin
      cif.done <= busy && (count == '0);
      if (busy && (count == '0)) begin
        cif.result <= held; // R3
        cif.outOfRange <= (held < cif.lowLimit) ||
          (held > cif.highLimit); // R9
        cif.zeroCross <= crossing; // R10
      end
    end
  end

  conv_latency_a: assert property ( // R2
    @(posedge clock) disable iff (!nrst || !ce)
    cif.start |-> ##DoneLat cif.done)
    else $error("conversion did not finish on time");

  zc_mode_a: assert property ( // R10
    @(posedge clock) disable iff (!nrst || !ce)
    cif.done && cif.zeroCross |-> cif.zcMode != 2'b00)
    else $error("zero crossing flagged while disabled");
endmodule

// ==== rtl/dasq_top.sv ====
`timescale 1ns/1ps
`include "dasq_params.svh"

module dasq_top #(
  parameter int CONV_CYCLES = `DASQ_CONV_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0][11:0] analogInput,
  input wire logic scanTriggerA,
  input wire logic scanTriggerB,
  output logic irq
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [7:0][11:0] anaS1; // First synchroniser stage
  logic [7:0][11:0] anaS2; // Stable input words
  logic [1:0] trigS1; // Trigger synchroniser, first stage
  logic [1:0] trigS2; // Trigger synchroniser, second stage
  logic [1:0] trigS3; // Delayed copy for edge detect
  logic trigEdge; // Rising edge on either trigger

  dasq_pkg::dasq_mode_t mode; // Scan behaviour
  logic simul; // Simultaneous pair conversion
  logic [7:0][2:0] chanList; // Input of each slot
  logic [2:0] lastSlot; // Final slot of the scan
  logic [15:0] zcSel; // Two bits of crossing mode per slot
  logic [11:0] results [8]; // Result buffers per slot
  logic [11:0] lowLim [8]; // Low limit per slot
  logic [11:0] highLim [8]; // High limit per slot
  logic [2:0] irqStat; // Sticky event flags
  logic [2:0] irqMask; // Event enables

  dasq_pkg::dasq_state_t state; // Sequencer state
  logic [2:0] slot; // Slot being converted
  logic stopReq; // Halt continuous scanning
  logic anyOut; // A result of this scan broke a limit

  logic rdValid; // Read data latched for this transfer
  logic [31:0] rdData; // Read multiplexer
  logic hit; // Address maps to a register
  logic wrEn; // Write taken this cycle
  logic startPulse; // Software start
  logic stopPulse; // Software stop
  logic go; // Begin a scan
  logic [2:0] endSlot; // Final slot after mode clamp
  logic [2:0] chanA; // Input for converter A
  logic [2:0] chanB; // Input for converter B
  logic [2:0] slotB; // Buffer slot fed by converter B
  logic doneAny; // A conversion of this slot ended
  logic scanEnd; // Final slot finished
  logic limitHit; // Scan broke a limit, current slot included
  logic [2:0] irqSet; // Events this cycle
  logic [2:0] irqClr; // Write-one-to-clear mask

  dasq_conv_if cifA ();
  dasq_conv_if cifB ();

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Analogue words and triggers come from outside this clock
  always_ff @(posedge clock) begin
    if (!nrst) begin
      anaS1 <= '0;
      anaS2 <= '0;
      trigS1 <= 2'h0;
      trigS2 <= 2'h0;
      trigS3 <= 2'h0;
    end else if (ce) begin
      anaS1 <= analogInput;
      anaS2 <= anaS1;
      trigS1 <= {scanTriggerB, scanTriggerA};
      trigS2 <= trigS1;
      trigS3 <= trigS2;
    end
  end

  assign trigEdge = |(trigS2 & ~trigS3);

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // Ready only once read data has been latched in a live cycle
  assign pready = ce && rdValid;
  assign pslverr = psel && penable && pready && !hit;
  assign wrEn = psel && penable && pwrite && pready && hit;
  assign irqClr = (wrEn && paddr == `DASQ_IRQST_OFS) ? pwdata[2:0]
    : 3'h0;
  assign startPulse = wrEn && paddr == `DASQ_CTRL_OFS &&
    pwdata[`DASQ_CTRL_START_BIT];
  assign stopPulse = wrEn && paddr == `DASQ_CTRL_OFS &&
    pwdata[`DASQ_CTRL_STOP_BIT];

  // Read multiplexer, reserved bits read zero
  always_comb begin
    rdData = 32'h0000_0000;
    hit = 1'b1;
    if (paddr == `DASQ_CTRL_OFS) begin
      rdData[2:0] = {simul, mode};
    end else if (paddr == `DASQ_STAT_OFS) begin
      rdData[4:0] = {stopReq, slot, state != dasq_pkg::ST_IDLE};
    end else if (paddr == `DASQ_LIST_OFS) begin
      rdData[26:0] = {lastSlot, chanList};
    end else if (paddr == `DASQ_ZCSEL_OFS) begin
      rdData[15:0] = zcSel;
    end else if (paddr == `DASQ_IRQST_OFS) begin
      rdData[2:0] = irqStat;
    end else if (paddr == `DASQ_IRQMSK_OFS) begin
      rdData[2:0] = irqMask;
    end else if (paddr[7:5] == `DASQ_RES_BLK) begin
      rdData[11:0] = results[paddr[4:2]];
    end else if (paddr[7:5] == `DASQ_LOLIM_BLK) begin
      rdData[11:0] = lowLim[paddr[4:2]];
    end else if (paddr[7:5] == `DASQ_HILIM_BLK) begin
      rdData[11:0] = highLim[paddr[4:2]];
    end else begin
      hit = 1'b0; // Unmapped: error response
    end
  end

  // Read data is caught in the setup cycle, so one access cycle
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdValid <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      rdValid <= psel && !(penable && rdValid);
      if (psel && !rdValid) begin
        prdata <= rdData;
      end
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Mode and list are locked while a scan runs to keep it coherent
  always_ff @(posedge clock) begin
    if (!nrst) begin
      mode <= dasq_pkg::MODE_ONCE;
      simul <= 1'b0;
      // One reset word holds both the list and its final slot
      chanList <= 24'(`DASQ_LIST_RST);
      lastSlot <= 3'(`DASQ_LIST_RST >> `DASQ_LIST_LAST_LSB);
      zcSel <= `DASQ_ZCSEL_RST;
      irqMask <= `DASQ_IRQ_RST;
    end else if (ce && wrEn) begin
      if (state == dasq_pkg::ST_IDLE) begin
        if (paddr == `DASQ_CTRL_OFS) begin
          mode <= dasq_pkg::dasq_mode_t'(pwdata[1:0]); // R1
          simul <= pwdata[`DASQ_CTRL_SIMUL_BIT]; // R4
        end
        if (paddr == `DASQ_LIST_OFS) begin
          chanList <= pwdata[23:0]; // R5
          lastSlot <= pwdata[`DASQ_LIST_LAST_LSB +: 3];
        end
      end
      if (paddr == `DASQ_ZCSEL_OFS) begin
        zcSel <= pwdata[15:0];
      end
      if (paddr == `DASQ_IRQMSK_OFS) begin
        irqMask <= pwdata[2:0];
      end
    end
  end

  // Limits may be retuned at any time
  always_ff @(posedge clock) begin
    if (!nrst) begin
      for (int i = 0; i < 8; i++) begin
        lowLim[i] <= `DASQ_LOLIM_RST;
        highLim[i] <= `DASQ_HILIM_RST;
      end
    end else if (ce && wrEn) begin
      if (paddr[7:5] == `DASQ_LOLIM_BLK) begin
        lowLim[paddr[4:2]] <= pwdata[11:0];
      end
      if (paddr[7:5] == `DASQ_HILIM_BLK) begin
        highLim[paddr[4:2]] <= pwdata[11:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Slot routing
  // ---------------------------------------------------------------
  // Simultaneous scans pair slot n with slot n+4, so at most four
  assign endSlot = (simul && lastSlot[2]) ? 3'h3 : lastSlot; // R4
  assign chanA = chanList[slot]; // R5
  assign slotB = simul ? {1'b1, slot[1:0]} : slot;
  assign chanB = chanList[slotB];
  // Software must keep the two inputs of a pair distinct
  assign cifA.sample = anaS2[chanA]; // R8
  assign cifB.sample = anaS2[chanB];
  // Sequential: inputs 0-3 on converter A, 4-7 on converter B
  assign cifA.start = state == dasq_pkg::ST_START &&
    (simul || !chanA[2]); // R6
  assign cifB.start = state == dasq_pkg::ST_START &&
    (simul || chanA[2]); // R7
  assign cifA.lowLimit = lowLim[slot];
  assign cifA.highLimit = highLim[slot];
  assign cifA.zcMode = zcSel[{slot, 1'b0} +: 2];
  assign cifA.prevResult = results[slot];
  assign cifB.lowLimit = lowLim[slotB];
  assign cifB.highLimit = highLim[slotB];
  assign cifB.zcMode = zcSel[{slotB, 1'b0} +: 2];
  assign cifB.prevResult = results[slotB];

  dasq_conv_slice #(.CONV_CYCLES(CONV_CYCLES)) convA (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .cif(cifA)
  );

  dasq_conv_slice #(.CONV_CYCLES(CONV_CYCLES)) convB (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .cif(cifB)
  );

  // ---------------------------------------------------------------
  // Scan sequencer
  // ---------------------------------------------------------------
  // Trigger edges outside idle are dropped, not queued
  // Start obeys the mode written with it, so one write can switch
  // into triggered mode without firing a stray scan
  assign go = state == dasq_pkg::ST_IDLE &&
    ((startPulse && pwdata[1:0] != dasq_pkg::MODE_TRIG) ||
    (trigEdge && mode == dasq_pkg::MODE_TRIG)); // R11
  assign doneAny = state == dasq_pkg::ST_WAIT &&
    (cifA.done || cifB.done);
  assign scanEnd = doneAny && slot == endSlot;
  assign limitHit = anyOut || (cifA.done && cifA.outOfRange) ||
    (cifB.done && cifB.outOfRange);

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state <= dasq_pkg::ST_IDLE;
      slot <= 3'h0;
      anyOut <= 1'b0;
    end else if (ce) begin
      unique case (state)
        dasq_pkg::ST_IDLE: begin
          if (go) begin
            state <= dasq_pkg::ST_START; // R11
            slot <= 3'h0;
            anyOut <= 1'b0;
          end
        end
        dasq_pkg::ST_START: begin
          state <= dasq_pkg::ST_WAIT;
        end
        dasq_pkg::ST_WAIT: begin
          if (doneAny) begin
            anyOut <= limitHit;
            if (slot != endSlot) begin
              state <= dasq_pkg::ST_START; // R5
              slot <= slot + 3'h1;
            end else if (mode == dasq_pkg::MODE_LOOP && !stopReq) begin
              state <= dasq_pkg::ST_START; // R1
              slot <= 3'h0;
              anyOut <= 1'b0;
            end else begin
              state <= dasq_pkg::ST_IDLE; // R1
            end
          end
        end
        default: state <= dasq_pkg::ST_IDLE;
      endcase
    end
  end

  // Stop takes effect at the end of the running scan
  always_ff @(posedge clock) begin
    if (!nrst) begin
      stopReq <= 1'b0;
    end else if (ce) begin
      if (stopPulse) begin
        stopReq <= 1'b1;
      end else if (state == dasq_pkg::ST_IDLE) begin
        stopReq <= 1'b0;
      end
    end
  end

  // Result buffers, written as each conversion ends
  always_ff @(posedge clock) begin
    if (!nrst) begin
      for (int i = 0; i < 8; i++) begin
        results[i] <= 12'h000;
      end
    end else if (ce) begin
      if (cifA.done) begin
        results[slot] <= cifA.result; // R3
      end
      if (cifB.done) begin
        results[slotB] <= cifB.result; // R3
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  always_comb begin
    irqSet = 3'h0;
    irqSet[`DASQ_IRQ_DONE_BIT] = scanEnd;
    irqSet[`DASQ_IRQ_LIMIT_BIT] = scanEnd && limitHit; // R9
    irqSet[`DASQ_IRQ_ZC_BIT] = (cifA.done && cifA.zeroCross) ||
      (cifB.done && cifB.zeroCross); // R10
  end

  // New events win over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (!nrst) begin
      irqStat <= `DASQ_IRQ_RST;
      irq <= 1'b0;
    end else if (ce) begin
      irqStat <= (irqStat & ~irqClr) | irqSet;
      irq <= |(irqStat & irqMask);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  once_halt_a: assert property ( // R1
    @(posedge clock) disable iff (!nrst || !ce)
    scanEnd && mode == dasq_pkg::MODE_ONCE |=>
      state == dasq_pkg::ST_IDLE)
    else $error("single scan did not halt");

  loop_restart_a: assert property ( // R1
    @(posedge clock) disable iff (!nrst || !ce)
    scanEnd && mode == dasq_pkg::MODE_LOOP && !stopReq |=>
      state == dasq_pkg::ST_START && slot == 3'h0)
    else $error("continuous scan did not restart");

  result_store_a: assert property ( // R3
    @(posedge clock) disable iff (!nrst || !ce)
    cifA.done |=> results[$past(slot)] == $past(cifA.result))
    else $error("result buffer not written");

  pair_clamp_a: assert property ( // R4
    @(posedge clock) disable iff (!nrst || !ce)
    simul && state != dasq_pkg::ST_IDLE |-> !slot[2])
    else $error("simultaneous scan ran past slot three");

  slot_step_a: assert property ( // R5
    @(posedge clock) disable iff (!nrst || !ce)
    doneAny && slot != endSlot |=>
      slot == $past(slot) + 3'h1 ##1 state == dasq_pkg::ST_WAIT)
    else $error("channel list not followed in order");

  seq_route_a: assert property ( // R6
    @(posedge clock) disable iff (!nrst || !ce)
    state == dasq_pkg::ST_START && !simul |->
      cifB.start == chanA[2] && cifA.start != cifB.start)
    else $error("sequential slot on wrong converter");

  simul_pair_a: assert property ( // R7
    @(posedge clock) disable iff (!nrst || !ce)
    state == dasq_pkg::ST_START && simul |-> cifA.start && cifB.start)
    else $error("pair not sampled together");

  limit_irq_a: assert property ( // R9
    @(posedge clock) disable iff (!nrst || !ce)
    scanEnd && limitHit |=> irqStat[`DASQ_IRQ_LIMIT_BIT] ##1
      irq == irqMask[`DASQ_IRQ_LIMIT_BIT] || irq)
    else $error("limit event lost");

  trig_start_a: assert property ( // R11
    @(posedge clock) disable iff (!nrst || !ce)
    trigEdge && mode == dasq_pkg::MODE_TRIG &&
      state == dasq_pkg::ST_IDLE |=> state == dasq_pkg::ST_START)
    else $error("trigger did not start a scan");

  trig_ignore_a: assert property ( // R11
    @(posedge clock) disable iff (!nrst || !ce)
    trigEdge && state == dasq_pkg::ST_WAIT && !doneAny |=>
      state == dasq_pkg::ST_WAIT && $stable(slot))
    else $error("trigger disturbed a running scan");
endmodule

// ==== sim/dasq_analog_model.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Far side: eight analogue words and two trigger pins
// ---------------------------------------------------------------
module dasq_analog_model (
  input wire logic clock,
  output logic [7:0][11:0] analogInput,
  output logic scanTriggerA,
  output logic scanTriggerB
);
  logic [11:0] base; // Level of input 0
  initial begin
    base = 12'h000;
    scanTriggerA = 1'b0;
    scanTriggerB = 1'b0;
  end
  // Distinct level per input, so a wrong channel pick shows up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      analogInput[i] = base + 12'(i * 12'h111);
    end
  end
  // New levels change only just after an edge
  task setBase(input logic [11:0] b);
    @(posedge clock);
    base <= b;
  endtask
  // Held four cycles: the design syncs the pin through two flops
  task fire(input logic sel);
    @(posedge clock);
    if (sel) begin
      scanTriggerB <= 1'b1;
    end else begin
      scanTriggerA <= 1'b1;
    end
    repeat (4) @(posedge clock);
    scanTriggerA <= 1'b0;
    scanTriggerB <= 1'b0;
  endtask
endmodule

// ==== sim/dual_adc_scan_sequencer_tb_top.sv ====
`timescale 1ns/1ps
module dual_adc_scan_sequencer_tb_top;
  // ---------------------------------------------------------------
  // Signals and counters
  // ---------------------------------------------------------------
  logic clock, nrst, ce, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic slvErr; // Error flag of the last transfer
  logic [7:0][11:0] analogInput;
  logic scanTriggerA, scanTriggerB;
  int errCount = 0;
  int checks = 0;
  int seqCyc, simCyc, c;

  // Short conversions keep the run brief
  dasq_top #(.CONV_CYCLES(2)) i_dut (.clock(clock), .nrst(nrst),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .analogInput(analogInput),
    .scanTriggerA(scanTriggerA), .scanTriggerB(scanTriggerB),
    .irq(irq));
  dasq_analog_model i_model (.clock(clock), .analogInput(analogInput),
    .scanTriggerA(scanTriggerA), .scanTriggerB(scanTriggerB));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task finishTest;
    $display("errors %0d checks %0d", errCount, checks);
    if (errCount == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; only the watchdog ends a wait for ready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    chk(32'(pready), 1);
    q = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next setup never lands in this time step
    @(posedge clock);
  endtask
  // Registered output: look in the middle of the cycle
  task chkIrq(input logic exp);
    @(negedge clock);
    chk(32'(irq), 32'(exp));
    @(posedge clock);
  endtask
  task waitIdle(output int n);
    n = 0;
    do begin
      apb(0, 8'h04, 0);
      n++;
    end while (q[0] !== 1'b0 && n < 200);
    chk(32'(q[0]), 0);
  endtask
  function logic [11:0] val(input logic [11:0] b, input int i);
    return b + 12'(i * 12'h111);
  endfunction
  // Result n holds input n, or input 7-n for the reversed list
  task chkRes(input logic [11:0] b, input int last, input bit rev);
    for (int n = 0; n <= last; n++) begin
      apb(0, 8'h20 + 8'(4 * n), 0);
      chk(32'(q[11:0]), 32'(val(b, rev ? 7 - n : n)));
    end
  endtask

  // Watchdog well beyond the expected several hundred cycles
  initial begin
    repeat (20000) @(posedge clock);
    errCount++;
    finishTest;
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    apb(0, 8'h08, 0);
    chk(q, 32'h07FA_C688);
    apb(0, 8'h60, 0);
    chk(q, 32'h0000_0FFF);
    apb(0, 8'h10, 0);
    chk(q, 0);
    apb(0, 8'h18, 0);
    chk(32'(slvErr), 1);
    // Single sequential scan, interrupt masked, unmasked, cleared
    i_model.setBase(12'h0A0);
    apb(1, 8'h00, 32'h0000_0008);
    waitIdle(seqCyc);
    chkRes(12'h0A0, 7, 0);
    apb(0, 8'h10, 0);
    chk(q, 1);
    chkIrq(0);
    apb(1, 8'h14, 1);
    chkIrq(1);
    apb(1, 8'h10, 1);
    chkIrq(0);
    // Reversed list of four slots, slot 0 over its high limit
    apb(1, 8'h08, 32'h0300_0977);
    i_model.setBase(12'h1B0);
    apb(1, 8'h60, 32'(val(12'h1B0, 7)) - 1);
    apb(1, 8'h00, 32'h0000_0008);
    waitIdle(c);
    chkRes(12'h1B0, 3, 1);
    apb(0, 8'h10, 0);
    chk(q, 3);
    // Simultaneous pairs n and n+4 hold distinct inputs
    apb(1, 8'h08, 32'h07FA_C688);
    apb(1, 8'h60, 32'h0000_0FFF);
    i_model.setBase(12'h050);
    apb(1, 8'h00, 32'h0000_000C);
    waitIdle(simCyc);
    chkRes(12'h050, 7, 0);
    chk(32'(simCyc < seqCyc), 1);
    // Triggered: start bit ignored, busy trigger dropped
    apb(1, 8'h00, 32'h0000_0009);
    apb(0, 8'h04, 0);
    chk(32'(q[0]), 0);
    i_model.setBase(12'h200);
    i_model.fire(0);
    apb(0, 8'h04, 0);
    chk(32'(q[0]), 1);
    i_model.setBase(12'h300);
    i_model.fire(1);
    waitIdle(c);
    repeat (40) @(posedge clock);
    chkRes(12'h200, 0, 0);
    i_model.fire(1);
    waitIdle(c);
    chkRes(12'h300, 0, 0);
    // Continuous scan, then slot 0 crosses midscale
    apb(1, 8'h0C, 3);
    i_model.setBase(12'h0A0);
    apb(1, 8'h00, 32'h0000_000A);
    repeat (80) @(posedge clock);
    apb(1, 8'h10, 7);
    apb(0, 8'h10, 0);
    chk(32'(q[2]), 0);
    apb(0, 8'h04, 0);
    chk(32'(q[0]), 1);
    i_model.setBase(12'h900);
    repeat (80) @(posedge clock);
    apb(1, 8'h00, 32'h0000_0012);
    waitIdle(c);
    apb(0, 8'h10, 0);
    chk(32'(q[2]), 1);
    // Clock enable low freezes a running single scan
    i_model.setBase(12'h400);
    apb(1, 8'h00, 32'h0000_0008);
    ce <= 1'b0;
    repeat (40) @(posedge clock);
    ce <= 1'b1;
    apb(0, 8'h04, 0);
    chk(32'(q[0]), 1);
    waitIdle(c);
    chkRes(12'h400, 7, 0);
    // Reset while idle clears mask, irq and result buffer 0
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    apb(0, 8'h14, 0);
    chk(q, 0);
    apb(0, 8'h20, 0);
    chk(q, 0);
    chkIrq(0);
    finishTest;
  end
endmodule
